// ==== dpw_dev_model.sv ====
// Behavioural model of one dual-port SRAM port with semaphore flags
`default_nettype none
module dpw_dev_model
	import dpw_pkg::*;
(
	// Port pins from the host
	input  wire dpw_pkg::dpw_ctl_s          ctl_i,
	input  wire logic [dpw_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [dpw_pkg::DATA_W-1:0] data_i,
	input  wire logic                       data_oe_i,
	// Data back to the host and count of host breaches
	output logic      [dpw_pkg::DATA_W-1:0] data_o,
	output logic      [7:0]                 viol_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
	logic [7:0]        flag;
	logic [DATA_W-1:0] pend;
	logic [DATA_W-1:0] last;
	logic [ADDR_W-1:0] pend_a;
	logic [1:0]        pend_ln;
	logic              arr_sel, sem_sel, wr_any, drive, both_off;
	logic              oe_low;
	realtime           t_wr = 0;
	realtime           t_sem = 0;
	// Access decode; one port only, so no contention between ports
	assign both_off = ctl_i.upper_byte_select_n && ctl_i.lower_byte_select_n;
	assign arr_sel  = !ctl_i.chip_select_n && !both_off &&
		ctl_i.flag_access_strobe_n;
	assign sem_sel  = !ctl_i.flag_access_strobe_n &&
		(ctl_i.chip_select_n || both_off);
	assign wr_any   = (arr_sel || sem_sel) && !ctl_i.write_strobe_n;
	// Drives only with write strobe high; otherwise the bus shows the inverse of the last value
	assign drive = (arr_sel || sem_sel) && ctl_i.write_strobe_n &&
		!ctl_i.output_enable_n;
	// Released bus shows the inverse, so a stale value never passes
	always @* begin
		if (drive) begin
			data_o = sem_sel ? {DATA_W{flag[addr_i[2:0]]}} :
				mem[addr_i];
			last = data_o;
		end else
			data_o = ~last;
	end
	// Follow data and lanes while the overlap lasts
	always @* if (wr_any) begin
		pend    = data_i;
		pend_ln = {!ctl_i.upper_byte_select_n, !ctl_i.lower_byte_select_n};
	end
	always @(posedge wr_any) begin
		t_wr   = $realtime;
		pend_a = addr_i;
		oe_low = !ctl_i.output_enable_n;
	end
	initial viol_o = 8'h00;
	// Commit at the first rising enable; pulse width checked there
	always @(negedge wr_any) begin
		if ($realtime - t_wr < ((oe_low &&
			T_WZ_NS + T_DW_NS > T_WP_NS) ? T_WZ_NS + T_DW_NS : T_WP_NS))
			viol_o = viol_o + 8'h01;
		if (sem_sel) begin
			// Lone port, so the contention window never opens
			flag[pend_a[2:0]] = pend[0];
			t_sem = $realtime;
		end else begin
			if (pend_ln[1])
				mem[pend_a][DATA_W-1:LANE_W] = pend[DATA_W-1:LANE_W];
			if (pend_ln[0])
				mem[pend_a][LANE_W-1:0] = pend[LANE_W-1:0];
		end
	end
	// Flag read back too soon after its write
	always @(posedge drive) if (sem_sel && $realtime - t_sem < T_SWRD_NS)
		viol_o = viol_o + 8'h01;
	// Both sides driving; checked after the edge's updates settle
	always @(posedge data_oe_i or posedge drive) begin
		#1;
		if (drive && data_oe_i)
			viol_o = viol_o + 8'h01;
	end
endmodule : dpw_dev_model
`default_nettype wire

// ==== dpw_host.sv ====
// Host controller driving one port of a dual-port SRAM with semaphores
//
// What this block does
// - Hold the access-select condition steady for at least 12 ns.
// - Address changes only while write strobe or selects are inactive.
// - Output enable low: pulse at least max(pulse, turnoff plus setup).
// - Output enable high: pulse may be as short as minimum width.
// - Host never drives data while the device may still drive it.
// - Write data held valid past the end of write.
// - Allow flag write-to-read time before reading the flag back.
// - Both-port flag writes separated by contention window to be fair.
// - Keep chip select high through flag write and read sequence.
`default_nettype none
module dpw_host
	import dpw_pkg::*;
(
	// Clock and reset
	input  wire logic                      mclk_i,
	input  wire logic                      rst_i,
	// User request and answer
	input  wire logic                      req_valid_i,
	input  wire dpw_pkg::dpw_req_s         req_i,
	output logic                           req_ready_o,
	output logic                           done_o,
	output logic [dpw_pkg::DATA_W-1:0]     rdata_o,
	output logic                           flag_o,
	// Port pins
	output dpw_pkg::dpw_ctl_s              ctl_o,
	output logic [dpw_pkg::ADDR_W-1:0]     addr_o,
	output logic [dpw_pkg::DATA_W-1:0]     data_o,
	output logic                           data_oe_o,
	input  wire logic [dpw_pkg::DATA_W-1:0] data_i
);
	import dpw_pkg::*;

	dpw_state_e        state, next_state;
	dpw_req_s          cur, next_cur;
	dpw_ctl_s          next_ctl;
	logic [CNT_W-1:0]  cnt, next_cnt;
	logic [ADDR_W-1:0] next_addr;
	logic [DATA_W-1:0] next_data;
	logic              next_oe;
	logic              next_ready, next_done, next_flag;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] din_sync;
	logic              is_wr, is_sem;

	// Data pins arrive from outside the clock domain
	dpw_sync #(.W(DATA_W)) u_sync (
		.mclk_i  (mclk_i),
		.rst_i   (rst_i),
		.async_i (data_i),
		.sync_o  (din_sync)
	);

	assign is_wr  = (cur.kind == CMD_ARR_WR) || (cur.kind == CMD_SEM_WR);
	assign is_sem = cur.kind[1];

	// Sequencer: selects first, strobe after, strobe released first
	always_comb begin
		next_state = state;
		next_cur   = cur;
		next_cnt   = cnt;
		next_ctl   = ctl_o;
		next_addr  = addr_o;
		next_data  = data_o;
		next_oe    = data_oe_o;
		next_ready = 1'b0;
		next_done  = 1'b0;
		next_rdata = rdata_o;
		next_flag  = flag_o;
		case (state)
			ST_IDLE: begin
				next_ready = 1'b1;
				next_ctl   = CTL_IDLE;
				next_oe    = 1'b0;
				if (req_valid_i && req_ready_o) begin
					next_ready = 1'b0;
					next_cur   = req_i;
					// Address moves only with every strobe inactive
					next_addr  = req_i.addr;
					next_state = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (is_sem) begin
					// Chip select stays high for flag traffic
					next_ctl.chip_select_n        = 1'b1;
					next_ctl.flag_access_strobe_n = 1'b0;
					next_ctl.upper_byte_select_n  = 1'b1;
					next_ctl.lower_byte_select_n  = 1'b1;
				end else begin
					next_ctl.chip_select_n        = 1'b0;
					next_ctl.flag_access_strobe_n = 1'b1;
					next_ctl.upper_byte_select_n  = ~cur.lanes[1];
					next_ctl.lower_byte_select_n  = ~cur.lanes[0];
				end
				next_ctl.output_enable_n = is_wr ? ~cur.oe_during_wr : 1'b0;
				next_cnt = '0; // Selects now held until DONE
				next_state = is_wr ? ST_PULSE : ST_READ;
			end
			ST_PULSE: begin
				// Selects settled a cycle before the strobe falls
				next_ctl.write_strobe_n = 1'b0;
				// Drive data only once device drivers are off
				next_oe   = ctl_o.output_enable_n || (cnt != '0);
				next_data = cur.data;
				next_cnt  = cnt + CNT_W'(1);
				if ((cur.oe_during_wr && cnt >= CNT_W'(WPOE_CYC)) ||
						(!cur.oe_during_wr && cnt >= CNT_W'(WP_CYC - 1))) begin
					next_oe    = 1'b1;
					next_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// Strobe rises first, ending the write
				next_ctl.write_strobe_n = 1'b1;
				// Output enable off with the strobe, so the device
				// never turns its drivers on under our held data
				next_ctl.output_enable_n = 1'b1;
				next_oe    = 1'b1;
				next_cnt   = '0;
				next_state = is_sem ? ST_GAP : ST_DONE;
			end
			ST_GAP: begin
				// Selects held while flag settles across ports
				next_oe  = 1'b0;
				next_cnt = cnt + CNT_W'(1);
				if (cnt >= CNT_W'(((SWRD_CYC > SPS_CYC) ? SWRD_CYC : SPS_CYC)
						- 1)) begin
					next_state = ST_DONE;
				end
			end
			ST_READ: begin
				next_cnt = cnt + CNT_W'(1);
				// Two sync stages plus access time
				if (cnt >= CNT_W'(RD_CYC + 2)) begin
					next_rdata = din_sync;
					next_flag  = din_sync[0];
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_ctl   = CTL_IDLE;
				next_oe    = 1'b0;
				next_done  = 1'b1;
				next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state       <= ST_IDLE;
			cur         <= '0;
			cnt         <= '0;
			ctl_o       <= CTL_IDLE;
			addr_o      <= '0;
			data_o      <= '0;
			data_oe_o   <= 1'b0;
			req_ready_o <= 1'b0;
			done_o      <= 1'b0;
			rdata_o     <= '0;
			flag_o      <= 1'b0;
		end else begin
			state       <= next_state;
			cur         <= next_cur;
			cnt         <= next_cnt;
			ctl_o       <= next_ctl;
			addr_o      <= next_addr;
			data_o      <= next_data;
			data_oe_o   <= next_oe;
			req_ready_o <= next_ready;
			done_o      <= next_done;
			rdata_o     <= next_rdata;
			flag_o      <= next_flag;
		end
	end

	// Address stable whenever a write overlap is live
	addr_stable_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!ctl_o.write_strobe_n |=> $stable(addr_o))
		else $error("address moved during write");
	// Strobe never falls in the same edge as chip select or the flag strobe
	strobe_after_sel_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(ctl_o.write_strobe_n) |-> $stable(ctl_o.chip_select_n) &&
		$stable(ctl_o.flag_access_strobe_n))
		else $error("select fell with write strobe");
	// Flag traffic keeps chip select high
	sem_cs_high_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!ctl_o.flag_access_strobe_n |-> ctl_o.chip_select_n)
		else $error("chip select low during flag access");
	// Data held one cycle past strobe release
	data_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(ctl_o.write_strobe_n) |-> data_oe_o && $stable(data_o))
		else $error("write data dropped at end of write");
	// No drive while the device may still drive with oe low
	no_clash_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(ctl_o.write_strobe_n) && !ctl_o.output_enable_n |-> !data_oe_o)
		else $error("host drove data over device drivers");
	// Write pulse lasts the minimum width
	sequence pulse_s;
		(!ctl_o.write_strobe_n && data_oe_o) [*1];
	endsequence
	pulse_width_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(ctl_o.write_strobe_n) && ctl_o.output_enable_n
		|-> pulse_s)
		else $error("write pulse too short");
	// Access-select pins held through the pulse and its end
	sel_steady_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!ctl_o.write_strobe_n |=> $stable(ctl_o.chip_select_n) &&
		$stable(ctl_o.flag_access_strobe_n) &&
		$stable(ctl_o.upper_byte_select_n) &&
		$stable(ctl_o.lower_byte_select_n))
		else $error("access select moved during write");
	// Device outputs stay off while write data is still held
	oe_off_end_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(ctl_o.write_strobe_n) |-> ctl_o.output_enable_n)
		else $error("output enable low at end of write");
	// Longer pulse when output enable stays low
	pulse_oe_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$fell(ctl_o.write_strobe_n) && !ctl_o.output_enable_n
		|-> !ctl_o.write_strobe_n [*2])
		else $error("pulse too short with output enable low");
	// Gap held before a flag read can follow
	sem_gap_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		$rose(ctl_o.write_strobe_n) && !ctl_o.flag_access_strobe_n
		|=> !ctl_o.flag_access_strobe_n)
		else $error("flag strobe released before write-to-read time");
	// Array write selects a byte lane
	arr_lane_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		!ctl_o.write_strobe_n && ctl_o.flag_access_strobe_n
		|-> !ctl_o.chip_select_n && !(ctl_o.upper_byte_select_n &&
		ctl_o.lower_byte_select_n))
		else $error("array write without lane");
endmodule : dpw_host
`default_nettype wire

// ==== dpw_pkg.sv ====
// Package for the dual-port SRAM write-cycle host controller
`default_nettype none
package dpw_pkg;
	// Port geometry
	localparam int ADDR_W = 13;
	localparam int DATA_W = 18;
	localparam int LANE_W = 9;
	// Clock and timing (times in ns, fastest grade)
	localparam int CLK_NS       = 40;
	localparam int T_EW_NS      = 12;
	localparam int T_WP_NS      = 12;
	localparam int T_WZ_NS      = 10;
	localparam int T_DW_NS      = 10;
	localparam int T_SWRD_NS    = 5;
	localparam int T_SPS_NS     = 5;
	localparam int T_DH_NS      = 0;
	localparam int T_RD_NS      = 15;
	// Least times round up; all but WZDW_CYC also floored at one cycle
	localparam int WP_CYC   = ((T_WP_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
		(T_WP_NS + CLK_NS - 1) / CLK_NS;
	localparam int WZDW_CYC = ((T_WZ_NS + T_DW_NS + CLK_NS - 1) / CLK_NS);
	localparam int WPOE_CYC = (WZDW_CYC > WP_CYC) ? WZDW_CYC : WP_CYC;
	localparam int SWRD_CYC = ((T_SWRD_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
		(T_SWRD_NS + CLK_NS - 1) / CLK_NS;
	localparam int SPS_CYC  = ((T_SPS_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
		(T_SPS_NS + CLK_NS - 1) / CLK_NS;
	localparam int RD_CYC   = ((T_RD_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 :
		(T_RD_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W    = 4;
	// Command kinds
	localparam logic [1:0] CMD_ARR_WR = 2'h0;
	localparam logic [1:0] CMD_ARR_RD = 2'h1;
	localparam logic [1:0] CMD_SEM_WR = 2'h2;
	localparam logic [1:0] CMD_SEM_RD = 2'h3;
	// User request
	typedef struct packed {
		logic [1:0]        kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [1:0]        lanes;
		logic              oe_during_wr;
	} dpw_req_s;
	// Port control pins, active low
	typedef struct packed {
		logic chip_select_n;
		logic write_strobe_n;
		logic output_enable_n;
		logic upper_byte_select_n;
		logic lower_byte_select_n;
		logic flag_access_strobe_n;
	} dpw_ctl_s;
	// Controller states
	typedef enum logic [6:0] {
		ST_IDLE  = 7'h01,
		ST_SETUP = 7'h02,
		ST_PULSE = 7'h04,
		ST_HOLD  = 7'h08,
		ST_READ  = 7'h10,
		ST_GAP   = 7'h20,
		ST_DONE  = 7'h40
	} dpw_state_e;
	localparam dpw_ctl_s CTL_IDLE = 6'h3F;
endpackage : dpw_pkg
`default_nettype wire

// ==== dpw_sync.sv ====
// Two-flop synchroniser bank for the port's returning data pins
`default_nettype none
module dpw_sync #(
	parameter int W = 18
) (
	// Clock and reset
	input  wire logic         mclk_i,
	input  wire logic         rst_i,
	// Asynchronous input and its synchronised copy
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta;
	logic [W-1:0] next_meta;
	logic [W-1:0] next_sync;

	// First stage feeds only the second
	always_comb begin
		next_meta = async_i;
		next_sync = meta;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			meta   <= '0;
			sync_o <= '0;
		end else begin
			meta   <= next_meta;
			sync_o <= next_sync;
		end
	end
endmodule : dpw_sync
`default_nettype wire

// ==== tb_dual_port_sram_write_cycle.sv ====
// Self-checking bench for the dual-port SRAM write-cycle host
`default_nettype none
module tb_dual_port_sram_write_cycle;
	import dpw_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic              mclk_i = 1'b0;
	logic              rst_i = 1'b1;
	logic              req_valid_i = 1'b0;
	dpw_req_s          req_i = '0;
	logic              req_ready_o, done_o, flag_o, data_oe_o;
	logic [DATA_W-1:0] rdata_o, host_data, dev_data;
	dpw_ctl_s          ctl_o;
	logic [ADDR_W-1:0] addr_o;
	logic [7:0]        viol;
	logic [DATA_W-1:0] shadow [8];
	logic [ADDR_W-1:0] adr [8];
	int                err_count = 0;
	int                num_checks = 0;
	int                seed = 32'h8aa6;
	int                i, k;
	logic [DATA_W-1:0] d;
	logic [1:0]        ln;
	dpw_host u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
		.rdata_o(rdata_o), .flag_o(flag_o), .ctl_o(ctl_o), .addr_o(addr_o),
		.data_o(host_data), .data_oe_o(data_oe_o), .data_i(dev_data));
	dpw_dev_model u_dev (.ctl_i(ctl_o), .addr_i(addr_o), .data_i(host_data),
		.data_oe_i(data_oe_o), .data_o(dev_data), .viol_o(viol));
	// Free-running clock
	always #20 mclk_i = ~mclk_i;
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done
	task automatic check_data(input logic [DATA_W-1:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t data %h want %h", $time, got, exp);
		end
	endtask : check_data
	task automatic check_bit(input logic got, exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t flag %b want %b", $time, got, exp);
		end
	endtask : check_bit
	// Bounded wait on ready (sel 0) or done (sel 1)
	task automatic wait_hi(input bit sel);
		int n;
		n = 0;
		while ((sel ? done_o : req_ready_o) !== 1'b1 && n < 60) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		if ((sel ? done_o : req_ready_o) !== 1'b1) begin
			err_count++;
			$display("BAD %0t no handshake", $time);
			test_done();
		end
	endtask : wait_hi
	// Request held until the taking edge, then answer awaited
	task automatic do_req(input logic [1:0] kd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] dt, input logic [1:0] lns, input logic oe);
		wait_hi(1'b0);
		req_i = '{kind: kd, addr: a, data: dt, lanes: lns, oe_during_wr: oe};
		req_valid_i = 1'b1;
		@(posedge mclk_i);
		#1;
		req_valid_i = 1'b0;
		wait_hi(1'b1);
	endtask : do_req
	function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n,
		input logic [1:0] l);
		merge = o;
		if (l[1])
			merge[DATA_W-1:LANE_W] = n[DATA_W-1:LANE_W];
		if (l[0])
			merge[LANE_W-1:0] = n[LANE_W-1:0];
	endfunction : merge
	// Main sequence
	initial begin
		repeat (12) @(posedge mclk_i);
		#1;
		rst_i = 1'b0;
		// Full writes, address corners at both ends
		for (i = 0; i < 8; i++) begin
			// Low bits carry the index so no two slots alias
			adr[i] = (i == 0) ? '0 : (i == 7) ? '1 :
				{(ADDR_W-3)'($random(seed)), 3'(i)};
			shadow[i] = DATA_W'($random(seed));
			do_req(CMD_ARR_WR, adr[i], shadow[i], 2'h3, i[0]);
		end
		// Random back-to-back traffic with partial lanes
		for (i = 0; i < 60; i++) begin
			k = $unsigned($random(seed)) % 8;
			d = DATA_W'($random(seed));
			ln = 2'($unsigned($random(seed)) % 3 + 1);
			if ($random(seed) & 1) begin
				do_req(CMD_ARR_WR, adr[k], d, ln, 1'($random(seed)));
				shadow[k] = merge(shadow[k], d, ln);
			end else begin
				do_req(CMD_ARR_RD, adr[k], d, ln, 1'b0);
				check_data(rdata_o, shadow[k]);
			end
		end
		// Flag write then read back, every flag, both values
		for (i = 0; i < 16; i++) begin
			do_req(CMD_SEM_WR, ADDR_W'(i % 8), {DATA_W{i[3]}}, 2'h0, i[0]);
			do_req(CMD_SEM_RD, ADDR_W'(i % 8), '0, 2'h0, 1'b0);
			check_data(rdata_o, {DATA_W{i[3]}});
			check_bit(flag_o, i[3]);
		end
		// Array left untouched by flag traffic
		do_req(CMD_ARR_RD, adr[7], '0, 2'h3, 1'b0);
		check_data(rdata_o, shadow[7]);
		check_data(DATA_W'(viol), '0);
		test_done();
	end
endmodule : tb_dual_port_sram_write_cycle
`default_nettype wire
